// File: include/frame_pkg.sv
// constants, types and register map of the frame handling control block
// How it works
// - short enable word, 24 bits, top byte 23:16
// - cleared short bit excludes that entry
// - extended enable word covers twelve entries
// - writes store even bits only, odd ignored
// - reads show each enable on both bits
// - receive status: strength, ok bit, field
// - auto checksum appends transmit CRC-16
// - no auto checksum: missing bytes underflow
// - receive check replaces checksum with status
// - no auto checksum: bytes stored unchanged
// - acknowledgements always carry their checksum
// - auto acknowledge twelve symbols after frame
// - strength shows latest or peak value
// - receive modes normal and looping
// - receive mode 11 disables symbol search
// - transmit modes normal and cyclic
// - transmit mode 11 sends pseudo-random data
package frame_pkg;
   localparam logic [11:0] short_en_low_off = 12'h004;
   localparam logic [11:0] short_en_mid_off = 12'h005;
   localparam logic [11:0] short_match_enable_high_off = 12'h006;
   localparam logic [11:0] ext_match_enable_low_off = 12'h008;
   localparam logic [11:0] ext_match_enable_mid_off = 12'h009;
   localparam logic [11:0] ext_match_enable_high_off = 12'h00a;
   localparam logic [11:0] frame_handling_control_off = 12'h00c;
   localparam logic [11:0] strength_off = 12'h010;
   localparam logic [11:0] event_off = 12'h011;
   localparam logic [7:0] frame_ctrl_reset = 8'h40;
   localparam logic [7:0] byte_reset = 8'h00;
   localparam int short_entries = 24;
   localparam int ext_entries = 12;
   localparam int symbol_ns = 16000;
   localparam int clk_ns = 40;
   localparam int ack_symbols = 12;
   localparam int ack_cycles = (ack_symbols * symbol_ns + clk_ns - 1) / clk_ns;
   localparam logic [15:0] crc_init = 16'h0000;
   localparam logic [15:0] crc_poly = 16'h1021;
   localparam logic [1:0] mode_normal = 2'b00;
   localparam logic [1:0] mode_loop = 2'b10;
   localparam logic [1:0] mode_special = 2'b11;

   typedef struct packed {
      logic status_append_select;
      logic auto_checksum;
      logic auto_ack;
      logic energy_scan;
      logic [1:0] rx_mode;
      logic [1:0] tx_mode;
   } frame_ctrl_s;

   typedef struct packed {
      logic valid;
      logic last;
      logic [7:0] data;
   } byte_stream_s;

   typedef enum logic [1:0] {
      ack_idle = 2'b00,
      ack_wait = 2'b01,
      ack_send = 2'b11
   } ack_state_e;
endpackage

// File: core/frame_handling_control.sv
// frame handling control: match enables, checksum, status append, auto ack, strength, test modes
`timescale 1ns/10ps
module frame_handling_control (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire frame_pkg::byte_stream_s rx_in,
   input wire logic [6:0] rx_correlation,
   input wire logic [6:0] source_match_result_index,
   input wire logic rx_ack_request,
   input wire logic rx_addr_accepted,
   input wire logic [7:0] strength_sample,
   input wire logic strength_sample_valid,
   output frame_pkg::byte_stream_s rx_out,
   input wire frame_pkg::byte_stream_s tx_in,
   input wire logic tx_queue_empty,
   output frame_pkg::byte_stream_s tx_out,
   output logic tx_underflow,
   output logic [23:0] short_match_enable,
   output logic [11:0] long_source_enable_word,
   output logic symbol_search_enable,
   output logic rx_queue_loop,
   output logic tx_queue_loop,
   output logic ack_start,
   output logic [7:0] signal_strength
);
   frame_pkg::frame_ctrl_s ctrl_q;
   frame_pkg::frame_ctrl_s rx_cfg_q;
   frame_pkg::frame_ctrl_s tx_cfg_q;
   logic [23:0] short_en_q;
   logic [11:0] ext_en_q;
   logic [7:0] strength_q;
   logic [7:0] events_q;
   logic wr_pend_q;
   logic [11:0] wr_addr_q;
   logic [31:0] rdata_q;
   logic rx_busy_q;
   logic tx_busy_q;
   logic [15:0] rx_crc_q;
   logic [15:0] tx_crc_q;
   logic [7:0] rx_hold_q;
   logic [1:0] rx_cnt_q;
   logic [1:0] tx_tail_q;
   logic rx_ok_q;
   frame_pkg::byte_stream_s rx_out_q;
   frame_pkg::byte_stream_s tx_out_q;
   logic underflow_q;
   frame_pkg::ack_state_e ack_q;
   logic [15:0] ack_cnt_q;
   logic [15:0] prn_q;
   logic [23:0] ext_read;
   logic [7:0] wbyte;
   logic addr_phase;
   logic [11:0] reg_idx;
   logic peak_armed_q;
   logic [15:0] rx_crc_next;
   logic [15:0] tx_crc_next;

   // one-byte crc step, msb first
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         r = (r[15] ^ d[i]) ? ((r << 1) ^ frame_pkg::crc_poly) : (r << 1);
      end
      return r;
   endfunction

   assign addr_phase = hsel && hready && htrans[1];
   // registers sit one to a word, so the decoded index is the byte address over four
   assign reg_idx = {2'b00, haddr[11:2]};
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_q;
   assign wbyte = hwdata[7:0];
   assign rx_crc_next = crc_step(rx_crc_q, rx_in.data);
   assign tx_crc_next = crc_step(tx_crc_q, tx_in.data);

   // each extended enable shows on both bits of its pair
   genvar g;
   generate
      for (g = 0; g < frame_pkg::ext_entries; g++) begin : g_ext
         assign ext_read[2*g] = ext_en_q[g];
         assign ext_read[2*g+1] = ext_en_q[g];
      end
   endgenerate

   // write address latched in address phase, data taken next cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 12'h000;
      end else begin
         wr_pend_q <= addr_phase && hwrite;
         wr_addr_q <= reg_idx;
      end
   end

   // register writes; odd extended bits are never stored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= frame_pkg::frame_ctrl_reset;
         short_en_q <= {3{frame_pkg::byte_reset}};
         ext_en_q <= 12'h000;
      end else if (wr_pend_q) begin
         if (wr_addr_q == frame_pkg::short_en_low_off) begin
            short_en_q[7:0] <= wbyte;
         end else if (wr_addr_q == frame_pkg::short_en_mid_off) begin
            short_en_q[15:8] <= wbyte;
         end else if (wr_addr_q == frame_pkg::short_match_enable_high_off) begin
            short_en_q[23:16] <= wbyte;
         end else if (wr_addr_q == frame_pkg::ext_match_enable_low_off) begin
            ext_en_q[3:0] <= {wbyte[6], wbyte[4], wbyte[2], wbyte[0]};
         end else if (wr_addr_q == frame_pkg::ext_match_enable_mid_off) begin
            ext_en_q[7:4] <= {wbyte[6], wbyte[4], wbyte[2], wbyte[0]};
         end else if (wr_addr_q == frame_pkg::ext_match_enable_high_off) begin
            ext_en_q[11:8] <= {wbyte[6], wbyte[4], wbyte[2], wbyte[0]};
         end else if (wr_addr_q == frame_pkg::frame_handling_control_off) begin
            ctrl_q <= wbyte;
         end
      end
   end

   // read data registered in the address phase; unmapped reads zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_q <= 32'h0000_0000;
      end else if (addr_phase && !hwrite) begin
         if (reg_idx == frame_pkg::short_en_low_off) begin
            rdata_q <= {24'h00_0000, short_en_q[7:0]};
         end else if (reg_idx == frame_pkg::short_en_mid_off) begin
            rdata_q <= {24'h00_0000, short_en_q[15:8]};
         end else if (reg_idx == frame_pkg::short_match_enable_high_off) begin
            rdata_q <= {24'h00_0000, short_en_q[23:16]};
         end else if (reg_idx == frame_pkg::ext_match_enable_low_off) begin
            rdata_q <= {24'h00_0000, ext_read[7:0]};
         end else if (reg_idx == frame_pkg::ext_match_enable_mid_off) begin
            rdata_q <= {24'h00_0000, ext_read[15:8]};
         end else if (reg_idx == frame_pkg::ext_match_enable_high_off) begin
            rdata_q <= {24'h00_0000, ext_read[23:16]};
         end else if (reg_idx == frame_pkg::frame_handling_control_off) begin
            rdata_q <= {24'h00_0000, ctrl_q};
         end else if (reg_idx == frame_pkg::strength_off) begin
            rdata_q <= {24'h00_0000, strength_q};
         end else if (reg_idx == frame_pkg::event_off) begin
            rdata_q <= {24'h00_0000, events_q};
         end else begin
            rdata_q <= 32'h0000_0000;
         end
      end
   end

   // cleared bits drop entries out of the matcher
   assign short_match_enable = short_en_q;
   assign long_source_enable_word = ext_en_q;
   assign symbol_search_enable = (rx_cfg_q.rx_mode != frame_pkg::mode_special);
   assign rx_queue_loop = (rx_cfg_q.rx_mode == frame_pkg::mode_loop);
   assign tx_queue_loop = (tx_cfg_q.tx_mode == frame_pkg::mode_loop);
   assign rx_out = rx_out_q;
   assign tx_out = tx_out_q;
   assign tx_underflow = underflow_q;
   assign ack_start = (ack_q == frame_pkg::ack_send);
   assign signal_strength = strength_q;

   // latch configuration only while no frame is in flight
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_cfg_q <= frame_pkg::frame_ctrl_reset;
         tx_cfg_q <= frame_pkg::frame_ctrl_reset;
         rx_busy_q <= 1'b0;
         tx_busy_q <= 1'b0;
      end else begin
         if (!rx_busy_q && !(rx_in.valid)) begin
            rx_cfg_q <= ctrl_q;
         end
         if (!tx_busy_q && !(tx_in.valid)) begin
            tx_cfg_q <= ctrl_q;
         end
         if (rx_in.valid) begin
            rx_busy_q <= !rx_in.last;
         end
         if (tx_in.valid || tx_tail_q != 2'd0) begin
            tx_busy_q <= !(tx_tail_q == 2'd1) && !(tx_in.valid && tx_in.last && !tx_cfg_q.auto_checksum);
         end
         // underflow aborts the frame, so the pulse cannot repeat
         if (tx_busy_q && tx_queue_empty && !tx_in.valid && tx_tail_q == 2'd0 &&
            tx_cfg_q.tx_mode == frame_pkg::mode_normal) begin
            tx_busy_q <= 1'b0;
         end
      end
   end

   // receive path: one byte held back so the checksum can be swapped for status
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_crc_q <= frame_pkg::crc_init;
         rx_hold_q <= 8'h00;
         rx_cnt_q <= 2'd0;
         rx_ok_q <= 1'b0;
         rx_out_q <= '0;
      end else begin
         rx_out_q.valid <= 1'b0;
         rx_out_q.last <= 1'b0;
         if (rx_in.valid && !rx_cfg_q.auto_checksum) begin
            rx_out_q <= rx_in;
         end else if (rx_in.valid && rx_in.last) begin
            // crc over all bytes, checksum included, leaves zero residue
            rx_ok_q <= (rx_crc_next == 16'h0000);
            rx_out_q <= '{valid: 1'b1, last: 1'b0, data: strength_q};
            rx_cnt_q <= 2'd3;
            rx_crc_q <= frame_pkg::crc_init;
         end else if (rx_in.valid) begin
            rx_crc_q <= rx_crc_next;
            rx_hold_q <= rx_in.data;
            rx_cnt_q <= (rx_cnt_q == 2'd2) ? 2'd2 : rx_cnt_q + 2'd1;
            if (rx_cnt_q != 2'd0) begin
               rx_out_q <= '{valid: 1'b1, last: 1'b0, data: rx_hold_q};
            end
         end else if (rx_cnt_q == 2'd3) begin
            rx_out_q <= '{valid: 1'b1, last: 1'b1, data: {rx_ok_q, rx_cfg_q.status_append_select ?
               source_match_result_index : rx_correlation}};
            rx_cnt_q <= 2'd0;
         end
      end
   end

   // auto acknowledge timer: ack checksum is made by the ack sender regardless
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ack_q <= frame_pkg::ack_idle;
         ack_cnt_q <= 16'h0000;
      end else begin
         case (ack_q)
            frame_pkg::ack_idle: begin
               if (rx_in.valid && rx_in.last && rx_cfg_q.auto_ack && rx_addr_accepted && rx_ack_request &&
                  rx_crc_next == 16'h0000) begin
                  ack_q <= frame_pkg::ack_wait;
                  ack_cnt_q <= 16'(frame_pkg::ack_cycles - 1);
               end
            end
            frame_pkg::ack_wait: begin
               if (ack_cnt_q == 16'h0001) begin
                  ack_q <= frame_pkg::ack_send;
               end
               ack_cnt_q <= ack_cnt_q - 16'h0001;
            end
            default: begin
               ack_q <= frame_pkg::ack_idle;
            end
         endcase
      end
   end

   // transmit path: pass bytes, append crc, or send pseudo-random stream
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_crc_q <= frame_pkg::crc_init;
         tx_tail_q <= 2'd0;
         tx_out_q <= '0;
         underflow_q <= 1'b0;
         prn_q <= 16'hffff;
      end else begin
         tx_out_q.valid <= 1'b0;
         tx_out_q.last <= 1'b0;
         underflow_q <= 1'b0;
         if (tx_cfg_q.tx_mode == frame_pkg::mode_special) begin
            prn_q <= crc_step(prn_q, 8'h00);
            tx_out_q <= '{valid: 1'b1, last: 1'b0, data: prn_q[15:8]};
         end else if (tx_tail_q == 2'd2) begin
            tx_out_q <= '{valid: 1'b1, last: 1'b0, data: tx_crc_q[15:8]};
            tx_tail_q <= 2'd1;
         end else if (tx_tail_q == 2'd1) begin
            tx_out_q <= '{valid: 1'b1, last: 1'b1, data: tx_crc_q[7:0]};
            tx_tail_q <= 2'd0;
            tx_crc_q <= frame_pkg::crc_init;
         end else if (tx_in.valid) begin
            tx_out_q <= '{valid: 1'b1, last: tx_in.last && !tx_cfg_q.auto_checksum, data: tx_in.data};
            tx_crc_q <= tx_in.last ? (tx_cfg_q.auto_checksum ? tx_crc_next : frame_pkg::crc_init) : tx_crc_next;
            if (tx_in.last && tx_cfg_q.auto_checksum) begin
               tx_tail_q <= 2'd2;
            end
         end else if (tx_busy_q && tx_queue_empty && tx_cfg_q.tx_mode == frame_pkg::mode_normal) begin
            underflow_q <= 1'b1;
         end
      end
   end

   // strength: latest sample, or peak since energy scan switched on
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         strength_q <= 8'h00;
      end else if (strength_sample_valid) begin
         if (!ctrl_q.energy_scan || !peak_armed_q || $signed(strength_sample) > $signed(strength_q)) begin
            strength_q <= strength_sample;
         end
      end else if (!ctrl_q.energy_scan) begin
         strength_q <= strength_q;
      end
   end

   // peak restarts from the first sample after energy scan is switched on
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         peak_armed_q <= 1'b0;
      end else if (!ctrl_q.energy_scan) begin
         peak_armed_q <= 1'b0;
      end else if (strength_sample_valid) begin
         peak_armed_q <= 1'b1;
      end
   end

   // sticky event bits, cleared by a read; set wins over clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         events_q <= 8'h00;
      end else begin
         events_q <= ((addr_phase && !hwrite && reg_idx == frame_pkg::event_off) ? 8'h00 : events_q) |
            {6'h00, ack_start, underflow_q};
      end
   end
endmodule

// File: verification/frame_handling_control_sva.sv
// assertion checker for the frame handling control block, with its bind
`timescale 1ns/10ps
module frame_handling_control_chk (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire frame_pkg::byte_stream_s rx_in,
   input wire frame_pkg::byte_stream_s rx_out,
   input wire frame_pkg::byte_stream_s tx_in,
   input wire frame_pkg::byte_stream_s tx_out,
   input wire logic tx_underflow,
   input wire logic [23:0] short_match_enable,
   input wire logic [11:0] long_source_enable_word,
   input wire logic ack_start
);
   localparam logic [11:0] sh_hi = frame_pkg::short_match_enable_high_off << 2;
   localparam logic [11:0] ex_lo = frame_pkg::ext_match_enable_low_off << 2;
   localparam logic [11:0] ex_mi = frame_pkg::ext_match_enable_mid_off << 2;
   localparam logic [11:0] ex_hi = frame_pkg::ext_match_enable_high_off << 2;
   logic req;
   // address phase accepted on this edge
   assign req = hsel && hready && htrans[1];
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_zero_wait: assert property (hreadyout) else $error("slave inserted a wait state");
   a_resp_okay: assert property (!hresp) else $error("slave gave an error response");
   a_short_top: assert property (req && hwrite && haddr == sh_hi |=> ##1
      short_match_enable[23:16] == $past(hwdata[7:0])) else $error("short enable top byte not stored");
   a_ext_even_store: assert property (req && hwrite && haddr == ex_lo |=> ##1
      long_source_enable_word[3:0] == {$past(hwdata[6]), $past(hwdata[4]), $past(hwdata[2]), $past(hwdata[0])})
      else $error("extended enable not taken from even bits");
   a_ext_dup_read: assert property (req && !hwrite && (haddr == ex_lo || haddr == ex_mi || haddr == ex_hi) |=>
      ((hrdata[7:0] >> 1) & 8'h55) == (hrdata[7:0] & 8'h55)) else $error("extended enable pair differs on read");
   a_unmapped_zero: assert property (req && !hwrite && haddr == 12'h0fc |=> hrdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_tx_tail_last: assert property (tx_in.valid && tx_in.last |-> ##[1:3] tx_out.valid && tx_out.last)
      else $error("transmit frame end not emitted");
   a_rx_tail_last: assert property (rx_in.valid && rx_in.last |-> ##[1:2] rx_out.valid && rx_out.last)
      else $error("receive frame end not emitted");
   a_underflow_pulse: assert property (tx_underflow |=> !tx_underflow) else $error("underflow longer than one cycle");
   a_ack_pulse: assert property (ack_start |=> !ack_start) else $error("ack start longer than one cycle");
endmodule
bind frame_handling_control frame_handling_control_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .rx_in(rx_in), .rx_out(rx_out), .tx_in(tx_in), .tx_out(tx_out),
   .tx_underflow(tx_underflow), .short_match_enable(short_match_enable),
   .long_source_enable_word(long_source_enable_word), .ack_start(ack_start));

// File: verification/tx_queue_model.sv
// host side transmit queue model feeding bytes to the block
`timescale 1ns/10ps
module tx_queue_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic start,
   input wire logic [3:0] count,
   input wire logic with_last,
   output frame_pkg::byte_stream_s tx_in,
   output logic tx_queue_empty
);
   logic [3:0] left_q;
   logic phase_q;
   // one byte every other cycle, the slow host case; data scrambled between bytes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         left_q <= 4'h0;
         phase_q <= 1'b0;
         tx_in <= '0;
      end else begin
         phase_q <= ~phase_q;
         tx_in.valid <= 1'b0;
         tx_in.data <= ~tx_in.data;
         if (start) begin
            left_q <= count;
         end else if (left_q != 4'h0 && phase_q) begin
            tx_in.valid <= 1'b1;
            tx_in.data <= 8'h10 + {4'h0, count - left_q};
            tx_in.last <= with_last && left_q == 4'h1;
            left_q <= left_q - 4'h1;
         end
      end
   end
   assign tx_queue_empty = (left_q == 4'h0);
endmodule

// File: verification/frame_handling_control_tb_top.sv
// self-checking testbench of the frame handling control block
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; $display("wrong value t=%0t got=%h exp=%h", $time, g, e); end end
module frame_handling_control_tb_top;
   logic hclk, hresetn, hsel, hwrite, ack_req, addr_ok, smp_ok, tx_start, tx_last;
   logic [11:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata;
   logic [6:0] rx_corr, src_idx;
   logic [7:0] smp_v, strength;
   logic [3:0] tx_count;
   logic [23:0] short_en;
   logic [11:0] long_en;
   logic hresp, tx_empty, tx_underflow, search_en, rx_loop, tx_loop, ack_start;
   wire hready;
   frame_pkg::byte_stream_s rx_in, rx_out, tx_in, tx_out;
   logic [8:0] rxq[$], txq[$];
   int err_count = 0, checks_done = 0;
   localparam logic [11:0] ctrl = frame_pkg::frame_handling_control_off;
   frame_handling_control uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
      .hresp(hresp), .rx_in(rx_in), .rx_correlation(rx_corr), .source_match_result_index(src_idx),
      .rx_ack_request(ack_req), .rx_addr_accepted(addr_ok), .strength_sample(smp_v),
      .strength_sample_valid(smp_ok), .rx_out(rx_out), .tx_in(tx_in), .tx_queue_empty(tx_empty), .tx_out(tx_out),
      .tx_underflow(tx_underflow), .short_match_enable(short_en), .long_source_enable_word(long_en),
      .symbol_search_enable(search_en), .rx_queue_loop(rx_loop), .tx_queue_loop(tx_loop), .ack_start(ack_start),
      .signal_strength(strength));
   tx_queue_model host (.hclk(hclk), .hresetn(hresetn), .start(tx_start), .count(tx_count),
      .with_last(tx_last), .tx_in(tx_in), .tx_queue_empty(tx_empty));
   // clock, 40 ns period
   initial begin
      hclk = 0;
      forever #20 hclk = ~hclk;
   end
   // collect the byte streams leaving the block
   always @(posedge hclk) begin
      if (rx_out.valid === 1'b1) rxq.push_back({rx_out.last, rx_out.data});
      if (tx_out.valid === 1'b1) txq.push_back({tx_out.last, tx_out.data});
   end
   function automatic logic [11:0] ad(input logic [11:0] o);
      return o << 2;
   endfunction
   // msb-first checksum, init and polynomial as the block uses
   function automatic logic [15:0] crc(input logic [7:0] b[$]);
      logic [15:0] c = frame_pkg::crc_init;
      foreach (b[i]) begin
         c ^= {b[i], 8'h00};
         repeat (8) c = c[15] ? (c << 1) ^ frame_pkg::crc_poly : c << 1;
      end
      return c;
   endfunction
   // one single transfer; waits on hready in both phases, no fixed latency assumed
   task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
      int n;
      @(posedge hclk);
      hsel <= 1; htrans <= 2'b10; hwrite <= w; haddr <= a;
      n = 0;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 0; htrans <= 2'b00; hwdata <= {24'h00_0000, d};
      n = 0;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata[7:0];
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1, a, d, q);
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      logic [7:0] q;
      bus(0, a, 8'h00, q);
      `CHK(q, e)
   endtask
   task automatic rx_frame(input logic [7:0] b[$]);
      // one idle edge so a fresh setting is latched before the frame starts
      @(posedge hclk);
      foreach (b[i]) begin
         rx_in <= '{1'b1, i == b.size() - 1, b[i]};
         @(posedge hclk);
      end
      rx_in <= '{1'b0, 1'b0, 8'h5a};
      repeat (2) @(posedge hclk);
   endtask
   task automatic smp(input logic [7:0] v);
      smp_v <= v; smp_ok <= 1;
      @(posedge hclk);
      smp_ok <= 0;
      @(posedge hclk);
   endtask
   task automatic t_regs;
      logic [11:0] a[5] = '{frame_pkg::short_match_enable_high_off, frame_pkg::ext_match_enable_low_off,
         frame_pkg::ext_match_enable_mid_off, frame_pkg::ext_match_enable_high_off, ctrl};
      for (int i = 0; i < 5; i++) rd(ad(a[i]), i == 4 ? 8'h40 : 8'h00);
      wr(ad(a[0]), 8'ha5);
      rd(ad(a[0]), 8'ha5);
      `CHK(short_en, 24'ha5_0000)
      for (int i = 1; i < 4; i++) wr(ad(a[i]), 8'h36);
      for (int i = 1; i < 4; i++) rd(ad(a[i]), 8'h3c);
      `CHK(long_en, 12'h666)
      wr(12'h0fc, 8'hff);
      rd(12'h0fc, 8'h00);
      $display("test regs done");
   endtask
   task automatic t_rx;
      logic [7:0] f[$];
      logic [15:0] c;
      smp(8'h2a);
      rx_corr <= 7'h15; src_idx <= 7'h33;
      for (int m = 0; m < 3; m++) begin
         wr(ad(ctrl), m == 2 ? 8'h00 : {m[0], 7'h40});
         f = '{8'h41, 8'h02, 8'h7e};
         c = crc(f);
         f.push_back(c[15:8]);
         f.push_back(c[7:0] ^ {7'h00, m == 1});
         rxq.delete();
         rx_frame(f);
         repeat (3) @(posedge hclk);
         `CHK(rxq[2], 9'h07e)
         `CHK(rxq[3], m == 2 ? {1'b0, c[15:8]} : 9'h02a)
         `CHK(rxq[4], m == 2 ? {1'b1, c[7:0]} : m == 0 ? 9'h195 : 9'h133)
      end
      $display("test rx done");
   endtask
   task automatic t_ack;
      logic [7:0] f[$];
      logic [15:0] c;
      int n;
      wr(ad(ctrl), 8'h60);
      addr_ok <= 1;
      for (int k = 1; k >= 0; k--) begin
         f = '{8'h61, 8'h88};
         c = crc(f);
         f.push_back(c[15:8]);
         f.push_back(c[7:0]);
         ack_req <= k[0];
         rx_frame(f);
         n = 0;
         while (ack_start !== 1'b1 && n < frame_pkg::ack_cycles + 20) begin
            @(posedge hclk);
            n++;
         end
         `CHK(n + 2 >= frame_pkg::ack_cycles - 3 && n + 2 <= frame_pkg::ack_cycles + 3, k[0])
      end
      ack_req <= 0;
      $display("test ack done");
   endtask
   task automatic t_strength;
      wr(ad(ctrl), 8'h50);
      smp(8'h30); smp(8'h55); smp(8'hf0); smp(8'h20);
      rd(ad(frame_pkg::strength_off), 8'h55);
      wr(ad(ctrl), 8'h40);
      smp(8'h05);
      rd(ad(frame_pkg::strength_off), 8'h05);
      $display("test strength done");
   endtask
   task automatic t_tx;
      logic [7:0] f[$] = '{8'h10, 8'h11, 8'h12};
      logic [15:0] c = crc(f);
      int n;
      txq.delete();
      tx_count <= 3; tx_last <= 1; tx_start <= 1;
      @(posedge hclk);
      tx_start <= 0;
      repeat (20) @(posedge hclk);
      for (int i = 0; i < 3; i++) `CHK(txq[i], {1'b0, f[i]})
      `CHK(txq[3], {1'b0, c[15:8]})
      `CHK(txq[4], {1'b1, c[7:0]})
      wr(ad(ctrl), 8'h00);
      tx_count <= 2; tx_last <= 0; tx_start <= 1;
      @(posedge hclk);
      tx_start <= 0;
      n = 0;
      while (tx_underflow !== 1'b1 && n < 40) begin
         @(posedge hclk);
         n++;
      end
      `CHK(tx_underflow, 1'b1)
      rd(ad(frame_pkg::event_off), 8'h03);
      hresetn <= 0;
      @(posedge hclk);
      hresetn <= 1;
      $display("test tx done");
   endtask
   task automatic t_modes;
      logic [1:0] md[3] = '{2'b00, 2'b10, 2'b11};
      int n;
      for (int i = 0; i < 3; i++) begin
         wr(ad(ctrl), {4'h4, md[i], md[i]});
         repeat (3) @(posedge hclk);
         `CHK(rx_loop, md[i] == 2'b10)
         `CHK(search_en, md[i] != 2'b11)
         `CHK(tx_loop, md[i] == 2'b10)
      end
      txq.delete();
      repeat (40) @(posedge hclk);
      `CHK(txq.size() > 1, 1'b1)
      $display("test modes done");
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // main sequence, inputs set at time zero
   initial begin
      hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'b010; hwdata = 0;
      rx_in = '0; rx_corr = 0; src_idx = 0; ack_req = 0; addr_ok = 0; smp_v = 0; smp_ok = 0;
      tx_start = 0; tx_count = 0; tx_last = 0;
      repeat (20) @(posedge hclk);
      hresetn <= 1;
      t_regs; t_rx; t_ack; t_strength; t_tx; t_modes;
      summarize;
   end
   // watchdog: the run needs about 10000 cycles
   initial begin
      #(40 * 40000);
      err_count++;
      summarize;
   end
endmodule
